// File: verilog/input_port_pkg.sv
// constants shared by the blocked input port and its synchroniser
// assumes one 125 MHz clock and a synchronous active-high reset
//
// Contract
// RQ1: thirty-two lines served as four 8-line blocks
// RQ2: pointer stays latched; data reads follow inputs
// RQ3: byte bit k carries block line k
// RQ4: status byte: busy, write pending, pointer
// RQ5: write pending high for write time after writes
// RQ6: host polls pending bit before next operation
// RQ7: board owns four addresses from its base; code owns fewer for a base above 60, no wrap past 63
// RQ8: data port driven only inside own range
`default_nettype none
package input_port_pkg;

  // ==========================================================
  // widths
  localparam int LINE_COUNT  = 32;
  localparam int BLOCK_W     = 8;
  localparam int BLOCK_COUNT = 4;
  localparam int PTR_W       = 6;
  localparam int HOST_ADDR_W = 10;
  localparam int BLOCK_SEL_W = 2;

  // ==========================================================
  // host addresses
  localparam logic [HOST_ADDR_W-1:0] INPUT_DATA_PORT_ADDR = 10'h300;
  localparam logic [HOST_ADDR_W-1:0] BLOCK_POINTER_ADDR   = 10'h301;

  // ==========================================================
  // status byte layout
  localparam int STATUS_BUSY_BIT    = 7;
  localparam int STATUS_PENDING_BIT = 6;
  localparam int STATUS_PTR_MSB     = 5;
  localparam int STATUS_PTR_LSB     = 0;
  localparam logic [BLOCK_W-1:0] PENDING_MASK = 8'h40;

  // ==========================================================
  // reset values and own-range size
  localparam logic [PTR_W-1:0]   POINTER_RESET = 6'h00;
  localparam logic [BLOCK_W-1:0] RDATA_RESET   = 8'h00;
  localparam logic [PTR_W-1:0]   BLOCKS_IN_RANGE = 6'h04;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS     = 8;
  localparam int WRITE_PENDING_NS  = 10000;
  localparam int WRITE_PENDING_CYC =
    (WRITE_PENDING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PEND_CNT_W = 11;
  localparam logic [PEND_CNT_W-1:0] PEND_LAST =
    PEND_CNT_W'(WRITE_PENDING_CYC - 1);
  localparam logic [PEND_CNT_W-1:0] PEND_ZERO = 11'h000;

  // ==========================================================
  // write pending states
  typedef enum logic [1:0] {
    PEND_IDLE   = 2'b01,
    PEND_ACTIVE = 2'b10
  } pend_state_t;

endpackage
`default_nettype wire

// File: verilog/input_line_sync.sv
// two-flop synchroniser for the input lines and the board switch
// assumes both groups are asynchronous to clock_i
`timescale 1ns/1ps
`default_nettype none
module input_line_sync (
  input  wire logic                                clock_i,
  input  wire logic                                rst_i,
  input  wire logic [input_port_pkg::LINE_COUNT-1:0] lines_i,
  input  wire logic [input_port_pkg::PTR_W-1:0]      switch_i,
  output var  logic [input_port_pkg::LINE_COUNT-1:0] lines_o,
  output var  logic [input_port_pkg::PTR_W-1:0]      switch_o
);
  import input_port_pkg::*;

  logic [LINE_COUNT-1:0] lines_meta;
  logic [PTR_W-1:0]      switch_meta;

  // ==========================================================
  // first stage feeds only the second stage
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      lines_meta  <= '0;
      switch_meta <= '0;
      lines_o     <= '0;
      switch_o    <= '0;
    end else begin
      lines_meta  <= lines_i;
      switch_meta <= switch_i;
      lines_o     <= lines_meta;
      switch_o    <= switch_meta;
    end
  end

endmodule
`default_nettype wire

// File: verilog/blocked_digital_input_port.sv
// blocked digital input port: 32 lines read as four 8-bit blocks
// through a latched block pointer and a data port
// assumes the host strobes come from logic on clock_i, while the
// input lines and the board address switch come from pins
`timescale 1ns/1ps
`default_nettype none
module blocked_digital_input_port (
  input  wire logic                                   clock_i,
  input  wire logic                                   rst_i,
  // host side, same clock domain
  input  wire logic [input_port_pkg::HOST_ADDR_W-1:0] host_addr_i,
  input  wire logic                                   host_rd_i,
  input  wire logic                                   host_wr_i,
  input  wire logic [input_port_pkg::BLOCK_W-1:0]     host_wdata_i,
  output var  logic [input_port_pkg::BLOCK_W-1:0]     host_rdata_o,
  output var  logic                                   host_rdata_oe_o,
  output var  logic                                   host_rdata_valid_o,
  // pins
  input  wire logic [input_port_pkg::LINE_COUNT-1:0]  lines_i,
  input  wire logic [input_port_pkg::PTR_W-1:0]       board_address_i,
  // status
  output var  logic                                   write_pending_o
);
  import input_port_pkg::*;

  // ==========================================================
  // helpers

  // offset of the pointer from the board base, modulo 64
  function automatic logic [PTR_W-1:0] ptr_offset(
    input logic [PTR_W-1:0] ptr,
    input logic [PTR_W-1:0] base
  );
    ptr_offset = ptr - base;
  endfunction

  // pointer lands on one of this board's blocks, from base up to base plus 3 and never past 63, with no wrap
  function automatic logic ptr_in_range(
    input logic [PTR_W-1:0] ptr,
    input logic [PTR_W-1:0] base
  );
    logic [PTR_W-1:0] off;
    off = ptr_offset(ptr, base);
    ptr_in_range = (ptr >= base) && (off < BLOCKS_IN_RANGE);
  endfunction

  // byte of one block; bit k is line k of that block
  function automatic logic [BLOCK_W-1:0] block_byte(
    input logic [LINE_COUNT-1:0]  lines,
    input logic [BLOCK_SEL_W-1:0] sel
  );
    block_byte = lines[sel*BLOCK_W +: BLOCK_W];
  endfunction

  // host address hits the data port
  function automatic logic hits_data_port(
    input logic [HOST_ADDR_W-1:0] addr
  );
    hits_data_port = (addr == INPUT_DATA_PORT_ADDR);
  endfunction

  // host address hits the pointer and status location
  function automatic logic hits_pointer(
    input logic [HOST_ADDR_W-1:0] addr
  );
    hits_pointer = (addr == BLOCK_POINTER_ADDR);
  endfunction

  // ==========================================================
  // synchronised pins
  logic [LINE_COUNT-1:0] lines_sync;
  logic [PTR_W-1:0]      board_base;

  input_line_sync u_sync (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .lines_i  (lines_i),
    .switch_i (board_address_i),
    .lines_o  (lines_sync),
    .switch_o (board_base)
  );

  // ==========================================================
  // access decode
  logic rd_data;
  logic rd_ptr;
  logic wr_any;
  logic wr_ptr;

  always_comb begin
    rd_data = host_rd_i && hits_data_port(host_addr_i);
    rd_ptr  = host_rd_i && hits_pointer(host_addr_i);
    wr_ptr  = host_wr_i && hits_pointer(host_addr_i);
    // a data write stores nothing but still starts pending
    wr_any  = wr_ptr || (host_wr_i && hits_data_port(host_addr_i));
  end

  // ==========================================================
  // block pointer
  logic [PTR_W-1:0] block_pointer;
  logic [PTR_W-1:0] next_block_pointer;

  always_comb begin
    next_block_pointer = block_pointer;
    if (wr_ptr) begin
      // bits 7:6 of the write data are dropped
      // held until the host writes it again, see RQ2
      next_block_pointer = host_wdata_i[PTR_W-1:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      block_pointer <= POINTER_RESET;
    end else begin
      block_pointer <= next_block_pointer;
    end
  end

  // ==========================================================
  // write pending timer
  pend_state_t           pend_state;
  pend_state_t           next_pend_state;
  logic [PEND_CNT_W-1:0] pend_cnt;
  logic [PEND_CNT_W-1:0] next_pend_cnt;
  logic                  next_write_pending;

  always_comb begin
    next_pend_state = pend_state;
    next_pend_cnt   = pend_cnt;
    case (pend_state)
      PEND_IDLE: begin
        if (wr_any) begin
          // high for the write time after each write, see RQ5
          next_pend_state = PEND_ACTIVE;
          next_pend_cnt   = PEND_LAST;
        end
      end
      PEND_ACTIVE: begin
        if (wr_any) begin
          // a new write restarts the full interval, see RQ5
          next_pend_cnt = PEND_LAST;
        end else if (pend_cnt == PEND_ZERO) begin
          next_pend_state = PEND_IDLE;
        end else begin
          next_pend_cnt = pend_cnt - 1'b1;
        end
      end
      default: begin
        next_pend_state = PEND_IDLE;
        next_pend_cnt   = PEND_ZERO;
      end
    endcase
    next_write_pending = (next_pend_state == PEND_ACTIVE);
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pend_state      <= PEND_IDLE;
      pend_cnt        <= PEND_ZERO;
      write_pending_o <= 1'b0;
    end else begin
      pend_state      <= next_pend_state;
      pend_cnt        <= next_pend_cnt;
      write_pending_o <= next_write_pending;
    end
  end

  // ==========================================================
  // read answer
  logic                   pending_now;
  logic [BLOCK_W-1:0]     status_byte;
  logic [PTR_W-1:0]       sel_offset;
  logic [BLOCK_SEL_W-1:0] block_sel;
  logic                   own_block;
  logic [BLOCK_W-1:0]     next_rdata;
  logic                   next_rdata_oe;
  logic                   next_rdata_valid;

  always_comb begin
    pending_now = (pend_state == PEND_ACTIVE);
    // busy follows pending: no other operation is outstanding
    status_byte = RDATA_RESET;
    status_byte[STATUS_BUSY_BIT]    = pending_now;           // see RQ4
    status_byte[STATUS_PENDING_BIT] = pending_now;           // see RQ6
    status_byte[STATUS_PTR_MSB:STATUS_PTR_LSB] = block_pointer;
    // blocks 0 to 3 at base plus index, see RQ7
    sel_offset = ptr_offset(block_pointer, board_base);
    block_sel  = sel_offset[BLOCK_SEL_W-1:0];
    own_block = ptr_in_range(block_pointer, board_base);
    next_rdata       = RDATA_RESET;
    next_rdata_oe    = 1'b0;
    next_rdata_valid = 1'b0;
    if (rd_ptr) begin
      // a read beside a write shows the old pointer
      next_rdata       = status_byte;                        // see RQ4
      next_rdata_oe    = 1'b1;
      next_rdata_valid = 1'b1;
    end else if (rd_data) begin
      // refused reads are still answered, oe stays low
      next_rdata_valid = 1'b1;
      if (own_block) begin
        // live lines of the block, bit k = line k, see RQ1 RQ3
        next_rdata    = block_byte(lines_sync, block_sel);
        next_rdata_oe = 1'b1;                                // see RQ8
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      host_rdata_o       <= RDATA_RESET;
      host_rdata_oe_o    <= 1'b0;
      host_rdata_valid_o <= 1'b0;
    end else begin
      host_rdata_o       <= next_rdata;
      host_rdata_oe_o    <= next_rdata_oe;
      host_rdata_valid_o <= next_rdata_valid;
    end
  end

endmodule
`default_nettype wire

// File: test/input_port_sva.sv
// checker for the blocked input port host interface
// assumes binding to the ports of the top module
`timescale 1ns/1ps
`default_nettype none
module input_port_sva (
  input wire logic       clock_i,
  input wire logic       rst_i,
  input wire logic [9:0] host_addr_i,
  input wire logic       host_rd_i,
  input wire logic       host_wr_i,
  input wire logic [7:0] host_wdata_i,
  input wire logic [7:0] host_rdata_o,
  input wire logic       host_rdata_oe_o,
  input wire logic       host_rdata_valid_o,
  input wire logic       write_pending_o
);
  // ==========================================
  // helper state
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic        dec;
  logic [10:0] cnt, next_cnt;
  logic [5:0]  ptr, next_ptr;
  assign dec = host_addr_i[9:1] == 9'h180;
  always_comb begin
    next_cnt = write_pending_o ? cnt + 11'h001 : 11'h000;
    next_ptr = ptr;
    if (host_wr_i && dec)
      next_cnt = 11'h001;
    if (host_wr_i && host_addr_i == 10'h301)
      next_ptr = host_wdata_i[5:0];
  end
  always_ff @(posedge clock_i) begin
    cnt <= rst_i ? 11'h000 : next_cnt;
    ptr <= rst_i ? 6'h00 : next_ptr;
  end
  sequence sts_rd;
    host_rd_i && host_addr_i == 10'h301;
  endsequence
  rd_answer_a:
    assert property (host_rd_i && dec |=> host_rdata_valid_o)
    else $error("decoded read not answered");
  valid_cause_a:
    assert property (host_rdata_valid_o |-> $past(host_rd_i) && $past(dec))
    else $error("answer without read");
  undriven_zero_a:
    assert property (!host_rdata_oe_o |-> host_rdata_o == 8'h00)
    else $error("data not zero when undriven");
  status_ptr_a:
    assert property (sts_rd |=> host_rdata_oe_o
      && host_rdata_o[5:0] == $past(ptr))
    else $error("status pointer field wrong");
  status_flags_a:
    assert property (sts_rd |=> host_rdata_o[7] == host_rdata_o[6]
      && host_rdata_o[6] == $past(write_pending_o))
    else $error("status flag bits wrong");
  pend_start_a:
    assert property (host_wr_i && dec |=> write_pending_o [*8])
    else $error("pending not raised by write");
  pend_len_a:
    assert property ($fell(write_pending_o) |-> $past(cnt) == 11'h4E2)
    else $error("pending length wrong");
  pend_cap_a:
    assert property (write_pending_o |-> cnt <= 11'h4E2)
    else $error("pending held too long");
endmodule
bind blocked_digital_input_port input_port_sva u_sva (.clock_i, .rst_i,
  .host_addr_i, .host_rd_i, .host_wr_i, .host_wdata_i, .host_rdata_o,
  .host_rdata_oe_o, .host_rdata_valid_o, .write_pending_o);
`default_nettype wire

// File: test/host_bus_model.sv
// host driver board model issuing strobed reads and writes
// assumes the port answers one edge after the strobe edge
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       oe_i,
  input  wire logic       valid_i,
  output var  logic [9:0] addr_o,
  output var  logic       rd_o,
  output var  logic       wr_o,
  output var  logic [7:0] wdata_o
);
  // ==========================================
  // bus cycles, lines inverted when released
  initial begin
    addr_o = 10'h0FF;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 8'h00;
  end
  task automatic write(input logic [9:0] a, input logic [7:0] d);
    @(negedge clock_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clock_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic read(input logic [9:0] a, output logic [7:0] d,
                      output logic o, output logic v);
    @(negedge clock_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clock_i);
    d = rdata_i;
    o = oe_i;
    v = valid_i;
    rd_o = 1'b0;
    addr_o = ~a;
  endtask
  task automatic wait_idle();
    logic [7:0] s;
    logic       o, v;
    int         n;
    n = 0;
    do begin
      read(10'h301, s, o, v);
      n++;
    end while ((s & 8'h40) !== 8'h00 && n < 2000);
  endtask
endmodule
`default_nettype wire

// File: test/test_blocked_digital_input_port.sv
// self-checking bench for the blocked digital input port
// assumes the host model and the bound checker are compiled
`timescale 1ns/1ps
`default_nettype none
module test_blocked_digital_input_port;
  import input_port_pkg::*;
  // ==========================================
  // stimulus and checks
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [9:0]  addr;
  logic        rd, wr, oe, valid, pend;
  logic [7:0]  wdata, rdata;
  logic [31:0] lines = 32'h0;
  logic [5:0]  base;
  int          bad_count = 0;
  int          n_compared = 0;
  always #4 clock_i = ~clock_i;
  blocked_digital_input_port i_dut (.clock_i, .rst_i, .host_addr_i(addr),
    .host_rd_i(rd), .host_wr_i(wr), .host_wdata_i(wdata),
    .host_rdata_o(rdata), .host_rdata_oe_o(oe), .host_rdata_valid_o(valid),
    .lines_i(lines), .board_address_i(base), .write_pending_o(pend));
  host_bus_model u_host (.clock_i, .rdata_i(rdata), .oe_i(oe),
    .valid_i(valid), .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata));
  function automatic logic in_rng(input logic [5:0] p, input logic [5:0] b);
    return p >= b && p - b < 6'h04;
  endfunction
  function automatic logic [7:0] exp_read(input logic [5:0] p, b,
                                          input logic [31:0] l);
    logic [5:0] d;
    d = p - b;
    return in_rng(p, b) ? l[{d[1:0], 3'b000} +: 8] : 8'h00;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clock_i);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] d;
    logic       o, v;
    logic [5:0] p;
    void'($urandom(32'h2f3678af));
    base = 6'($urandom_range(60, 1));
    repeat (8) @(negedge clock_i);
    rst_i = 1'b0;
    for (int i = -1; i < 6; i++) begin
      p = base + 6'(i);
      u_host.write(10'h301, {2'($urandom), p});
      chk({7'h00, pend}, 8'h01);
      u_host.wait_idle();
      u_host.read(10'h301, d, o, v);
      chk(d, {2'b00, p});
      repeat (2) begin
        lines = $urandom;
        repeat (3) @(negedge clock_i);
        u_host.read(10'h300, d, o, v);
        chk(d, exp_read(p, base, lines));
        chk({6'h00, o, v}, {6'h00, in_rng(p, base), 1'b1});
      end
    end
    u_host.read(10'h302, d, o, v);
    chk({7'h00, v}, 8'h00);
    u_host.write(10'h300, 8'($urandom));
    u_host.read(10'h301, d, o, v);
    chk(d, {2'b11, p});
    tally_and_finish();
  end
endmodule
`default_nettype wire
